//--- rtl/tsp_core.sv
// touch sense control core: power states, scan, baselines, wake pin, leds
// Functional notes
// - power state follows the standby and lowest power control bits
// - any power state change clears touches on now inactive channels
// - standby scans only the standby subset, still interrupts, standby bit exit
// - deep sleep samples nothing; leds static at non-actuated level, no pwm
// - bus traffic wakes deep sleep temporarily; lowest power bit kept
// - wake pin high in deep sleep without spi4 clears lowest power bit
// - reset pin high holds everything in reset, leds undriven, state cleared
// - reset pin release sets reset status bit and raises an interrupt
// - with spi4 configured the wake pin is only the data input
// - standby without spi4 drives wake high on touch until interrupt cleared
// - in deep sleep the wake pin is an undriven input
// - each led linked to its own input or host driven; push-pull or open-drain
// - direct mode follows stimulus, optional invert, brightness, ramps, off delay
// - pulse1 pulses a programmed count, triggered on press or release
// - pulse2 pulses while actuated then a programmed count after release
// - breathe ramps between min and max while actuated at programmed rate
// - host driven unlinked led may raise alert when its behaviour ends
// - scans run back to back over enabled inputs, first to last
// - measurement minus baseline at threshold flags touch and interrupt
// - calibrate bit recalibrates, self clears, press restarts it, about 200ms
// - leaving standby for active recalibrates enabled inputs outside the standby subset; leaving sleep recalibrates all
// - baseline refreshed from 64 untouched samples, suspended during touch
// - interrupts set the interrupt bit; alert released when host clears it
`timescale 1ns/1ps
`default_nettype none
module tsp_core
  import tsp_pkg::*;
#(
  parameter int CAL_CYCLES = CAL_CYC,
  parameter int PRE_DIV    = PRE_DIV_DEF
) (
  input  wire logic                i_clk_sys,
  input  wire logic                i_reset_n,
  input  wire logic                i_reset_pin,
  input  wire logic                i_low_power_monitor_bit,
  input  wire logic                i_lowest_power_set,
  input  wire logic                i_bus_active,
  input  wire logic                i_spi4_mode,
  input  wire logic                i_wake_in,
  input  wire logic [NCH-1:0]      i_chan_en,
  input  wire logic [NCH-1:0]      i_standby_en,
  input  wire logic [NCH-1:0]      i_cal_set,
  input  wire logic                i_auto_recal_en,
  input  wire logic [MW-1:0]       i_threshold,
  input  wire logic                i_meas_valid,
  input  wire logic [MW-1:0]       i_meas_data,
  input  wire logic                i_int_clr,
  input  wire logic                i_reset_status_clr,
  input  wire logic [2*NLED-1:0]   i_led_mode,
  input  wire logic [NLED-1:0]     i_led_link,
  input  wire logic [NLED-1:0]     i_led_host,
  input  wire logic [NLED-1:0]     i_led_inv,
  input  wire logic [NLED-1:0]     i_led_od,
  input  wire logic [NLED-1:0]     i_led_ramp,
  input  wire logic [NLED-1:0]     i_led_trig_rel,
  input  wire logic [NLED-1:0]     i_led_alert_en,
  input  wire logic [DW*NLED-1:0]  i_led_min,
  input  wire logic [DW*NLED-1:0]  i_led_max,
  input  wire logic [DW*NLED-1:0]  i_led_count,
  input  wire logic [DW*NLED-1:0]  i_led_offdly,
  input  wire logic [8*NLED-1:0]   i_led_rate,
  output logic                     o_meas_req,
  output logic [2:0]               o_meas_chan,
  output logic [NCH-1:0]           o_touch,
  output logic [NCH-1:0]           o_cal_active,
  output logic [1:0]               o_pwr_state,
  output logic                     o_lowest_power_bit,
  output logic                     o_reset_status,
  output logic                     o_int_bit,
  output logic                     o_alert_n,
  output logic                     o_wake_out,
  output logic                     o_wake_oe,
  output logic [NLED-1:0]          o_led_out,
  output logic [NLED-1:0]          o_led_oe
);
  localparam int CW = $clog2(CAL_CYCLES + 1);
  localparam int PW = $clog2(PRE_DIV + 1);

  function automatic logic [NCH-1:0] act_mask(tsp_pwr_t p, logic [NCH-1:0] en, logic [NCH-1:0] se);
    case (p)
      PS_ACTIVE:  act_mask = en;
      PS_STANDBY: act_mask = en & se;
      default:    act_mask = TOUCH_RST;
    endcase
  endfunction

  function automatic logic [MW-1:0] sat_diff(logic [MW-1:0] a, logic [MW-1:0] b);
    sat_diff = (a > b) ? a - b : {MW{1'b0}};
  endfunction

  logic [1:0]            pin_sync_reg, wake_sync_reg;
  logic                  pin_last_reg, rst, pin_rel;
  tsp_pwr_t              ps_reg, ps_next;
  logic [NCH-1:0]        act_reg, act_next, recal_trig, cal_req;
  logic                  lp_reg, rst_stat_reg, int_reg, int_next, alert_n_reg;
  logic                  wake_reg, wake_oe_reg, wake_hit;
  logic [2:0]            ch_reg;
  logic                  req_reg, mv, hit, new_touch, cal_end, cal_bad;
  logic [NCH-1:0]        touch_reg, cal_reg, seen_reg;
  logic [CW-1:0]         cal_cnt_reg;
  logic [MW-1:0]         base_mem [NCH];
  logic [MW+AVG_SH-1:0]  sum_mem [NCH];
  logic [5:0]            acnt_mem [NCH];
  logic [MW-1:0]         diff;
  logic [MW+AVG_SH-1:0]  sum_add;

  // reset pin and wake pin synchronisers
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      pin_sync_reg  <= 2'b00;
      wake_sync_reg <= 2'b00;
      pin_last_reg  <= 1'b0;
    end else begin
      pin_sync_reg  <= {pin_sync_reg[0], i_reset_pin};
      wake_sync_reg <= {wake_sync_reg[0], i_wake_in};
      pin_last_reg  <= pin_sync_reg[1];
    end
  end

  assign rst      = !i_reset_n || pin_sync_reg[1];
  assign pin_rel  = pin_last_reg && !pin_sync_reg[1];
  assign wake_hit = (ps_reg == PS_SLEEP) && !i_spi4_mode && wake_sync_reg[1];

  // power state selection
  always_comb begin
    if (lp_reg && !i_bus_active) begin
      ps_next = PS_SLEEP;
    end else if (i_low_power_monitor_bit) begin
      ps_next = PS_STANDBY;
    end else begin
      ps_next = PS_ACTIVE;
    end
    act_next   = act_mask(ps_next, i_chan_en, i_standby_en);
    recal_trig = TOUCH_RST;
    if (ps_reg == PS_STANDBY && ps_next == PS_ACTIVE) begin
      recal_trig = i_chan_en & ~i_standby_en;
    end else if (ps_reg == PS_SLEEP && ps_next != PS_SLEEP) begin
      recal_trig = CAL_ALL;
    end
    cal_req = i_cal_set | recal_trig;
  end

  always_ff @(posedge i_clk_sys) begin
    if (rst) begin
      ps_reg  <= PS_SLEEP;
      act_reg <= TOUCH_RST;
      lp_reg  <= 1'b1;
    end else begin
      ps_reg  <= ps_next;
      act_reg <= act_next;
      if (i_lowest_power_set) begin
        lp_reg <= 1'b1;
      end else if (wake_hit) begin
        lp_reg <= 1'b0;
      end
    end
  end

  // scan sequencer
  always_ff @(posedge i_clk_sys) begin
    if (rst) begin
      ch_reg  <= 3'h0;
      req_reg <= 1'b0;
    end else if (req_reg) begin
      if (i_meas_valid) begin
        req_reg <= 1'b0;
        ch_reg  <= ch_reg + 3'h1;
      end
    end else if (act_reg[ch_reg] && ps_reg != PS_SLEEP) begin
      req_reg <= 1'b1;
    end else begin
      ch_reg <= ch_reg + 3'h1;
    end
  end

  assign mv        = req_reg && i_meas_valid;
  assign diff      = sat_diff(i_meas_data, base_mem[ch_reg]);
  assign hit       = diff >= i_threshold;
  assign new_touch = mv && hit && !cal_reg[ch_reg] && !touch_reg[ch_reg] && act_reg[ch_reg];
  assign cal_end   = (|cal_reg) && cal_cnt_reg == CW'(CAL_CYCLES - 1);
  assign cal_bad   = mv && cal_reg[ch_reg] && seen_reg[ch_reg] && hit;
  assign sum_add   = sum_mem[ch_reg] + {6'h00, i_meas_data};

  // manual and transition recalibration
  always_ff @(posedge i_clk_sys) begin
    if (rst) begin
      cal_reg     <= TOUCH_RST;
      seen_reg    <= TOUCH_RST;
      cal_cnt_reg <= {CW{1'b0}};
    end else if (cal_end) begin
      cal_reg     <= cal_req;
      seen_reg    <= TOUCH_RST;
      cal_cnt_reg <= {CW{1'b0}};
    end else begin
      cal_reg <= cal_reg | cal_req;
      if (mv && cal_reg[ch_reg]) begin
        seen_reg[ch_reg] <= 1'b1;
      end
      if ((|cal_req) || cal_bad || !(|cal_reg)) begin
        cal_cnt_reg <= {CW{1'b0}};
      end else begin
        cal_cnt_reg <= cal_cnt_reg + 1'b1;
      end
    end
  end

  // baselines and running average
  always_ff @(posedge i_clk_sys) begin
    if (rst) begin
      for (int c = 0; c < NCH; c++) begin
        base_mem[c] <= {MW{1'b0}};
        sum_mem[c]  <= {(MW+AVG_SH){1'b0}};
        acnt_mem[c] <= 6'h00;
      end
    end else if (mv) begin
      if (cal_reg[ch_reg]) begin
        sum_mem[ch_reg]  <= {(MW+AVG_SH){1'b0}};
        acnt_mem[ch_reg] <= 6'h00;
        if (!seen_reg[ch_reg] || !hit) begin
          base_mem[ch_reg] <= i_meas_data;
        end
      end else if (hit || !i_auto_recal_en) begin
        sum_mem[ch_reg]  <= {(MW+AVG_SH){1'b0}};
        acnt_mem[ch_reg] <= 6'h00;
      end else if (acnt_mem[ch_reg] == AVG_LAST) begin
        base_mem[ch_reg] <= MW'(sum_add >> AVG_SH);
        sum_mem[ch_reg]  <= {(MW+AVG_SH){1'b0}};
        acnt_mem[ch_reg] <= 6'h00;
      end else begin
        sum_mem[ch_reg]  <= sum_add;
        acnt_mem[ch_reg] <= acnt_mem[ch_reg] + 6'h01;
      end
    end
  end

  // touch status
  always_ff @(posedge i_clk_sys) begin
    if (rst) begin
      touch_reg <= TOUCH_RST;
    end else if (ps_next != ps_reg) begin
      touch_reg <= touch_reg & act_next;
    end else if (mv) begin
      touch_reg[ch_reg] <= hit && !cal_reg[ch_reg] && act_reg[ch_reg];
    end
  end

  // led engines
  tsp_led_mode_t         md [NLED];
  logic [DW-1:0]         lvl_reg [NLED], lvl_next [NLED], cnt_reg [NLED], cnt_next [NLED];
  logic [DW-1:0]         dly_reg [NLED], dly_next [NLED], mn, mx, tgt;
  logic [7:0]            rc_reg [NLED];
  logic [NLED-1:0]       up_reg, up_next, run_reg, run_next, last_reg, stim, tick, done, led_on;
  logic [NLED-1:0]       led_out_reg, led_oe_reg;
  logic [PW-1:0]         pre_reg;
  logic [DW-1:0]         pwm_reg;
  logic                  pre_tick, led_alert;

  assign pre_tick = pre_reg == PW'(PRE_DIV - 1);

  always_comb begin
    led_alert = 1'b0;
    mn  = LVL_OFF;
    mx  = LVL_OFF;
    tgt = LVL_OFF;
    for (int i = 0; i < NLED; i++) begin
      md[i]       = tsp_led_mode_t'(i_led_mode[2*i +: 2]);
      mn          = i_led_min[DW*i +: DW];
      mx          = i_led_max[DW*i +: DW];
      tick[i]     = pre_tick && rc_reg[i] == i_led_rate[8*i +: 8];
      stim[i]     = i_led_link[i] ? touch_reg[i] : i_led_host[i];
      lvl_next[i] = lvl_reg[i];
      cnt_next[i] = cnt_reg[i];
      dly_next[i] = dly_reg[i];
      up_next[i]  = up_reg[i];
      run_next[i] = run_reg[i];
      done[i]     = 1'b0;
      led_on[i]   = lvl_reg[i] == LVL_FULL || lvl_reg[i] > pwm_reg;
      case (md[i])
        LM_DIRECT: begin
          stim[i] = stim[i] ^ i_led_inv[i];
          if (last_reg[i] && !stim[i]) begin
            dly_next[i] = i_led_offdly[DW*i +: DW];
          end else if (tick[i] && dly_reg[i] != LVL_OFF) begin
            dly_next[i] = dly_reg[i] - 1'b1;
          end
          tgt = (stim[i] || dly_reg[i] != LVL_OFF) ? mx : LVL_OFF;
          if (!i_led_ramp[i]) begin
            lvl_next[i] = tgt;
          end else if (tick[i] && lvl_reg[i] < tgt) begin
            lvl_next[i] = lvl_reg[i] + 1'b1;
          end else if (tick[i] && lvl_reg[i] > tgt) begin
            lvl_next[i] = lvl_reg[i] - 1'b1;
          end
        end
        LM_PULSE1: begin
          if (i_led_trig_rel[i] ? (last_reg[i] && !stim[i]) : (stim[i] && !last_reg[i])) begin
            run_next[i] = 1'b1;
            cnt_next[i] = i_led_count[DW*i +: DW];
          end
        end
        LM_PULSE2: begin
          if (stim[i]) begin
            run_next[i] = 1'b1;
            cnt_next[i] = i_led_count[DW*i +: DW];
          end
        end
        LM_BREATHE: begin
          run_next[i] = stim[i];
        end
        default: begin
          run_next[i] = 1'b0;
        end
      endcase
      if (md[i] != LM_DIRECT) begin
        if (!run_reg[i]) begin
          lvl_next[i] = mn;
          up_next[i]  = 1'b1;
        end else if (tick[i] && up_reg[i]) begin
          if (lvl_reg[i] >= mx) begin
            up_next[i] = 1'b0;
          end else begin
            lvl_next[i] = lvl_reg[i] + 1'b1;
          end
        end else if (tick[i]) begin
          if (lvl_reg[i] > mn) begin
            lvl_next[i] = lvl_reg[i] - 1'b1;
          end else begin
            up_next[i] = 1'b1;
            if (md[i] == LM_PULSE1 || (md[i] == LM_PULSE2 && !stim[i])) begin
              if (cnt_reg[i] <= 4'h1) begin
                run_next[i] = 1'b0;
                done[i]     = 1'b1;
              end else begin
                cnt_next[i] = cnt_reg[i] - 1'b1;
              end
            end
          end
        end
      end
      if (done[i] && !i_led_link[i] && i_led_alert_en[i]) begin
        led_alert = 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (rst) begin
      pre_reg     <= {PW{1'b0}};
      pwm_reg     <= LVL_OFF;
      up_reg      <= 2'h0;
      run_reg     <= 2'h0;
      last_reg    <= 2'h0;
      led_out_reg <= 2'h0;
      led_oe_reg  <= 2'h0;
      for (int i = 0; i < NLED; i++) begin
        lvl_reg[i] <= LVL_OFF;
        cnt_reg[i] <= LVL_OFF;
        dly_reg[i] <= LVL_OFF;
        rc_reg[i]  <= 8'h00;
      end
    end else begin
      pre_reg <= pre_tick ? {PW{1'b0}} : pre_reg + 1'b1;
      pwm_reg <= pwm_reg + 1'b1;
      for (int i = 0; i < NLED; i++) begin
        if (pre_tick) begin
          rc_reg[i] <= tick[i] ? 8'h00 : rc_reg[i] + 8'h01;
        end
        if (ps_next == PS_SLEEP) begin
          lvl_reg[i]     <= LVL_OFF;
          run_reg[i]     <= 1'b0;
          dly_reg[i]     <= LVL_OFF;
          last_reg[i]    <= 1'b0;
          led_out_reg[i] <= i_led_od[i] ? 1'b0 : i_led_inv[i];
          led_oe_reg[i]  <= i_led_od[i] ? i_led_inv[i] : 1'b1;
        end else begin
          lvl_reg[i]     <= lvl_next[i];
          cnt_reg[i]     <= cnt_next[i];
          dly_reg[i]     <= dly_next[i];
          up_reg[i]      <= up_next[i];
          run_reg[i]     <= run_next[i];
          last_reg[i]    <= stim[i];
          led_out_reg[i] <= i_led_od[i] ? 1'b0 : led_on[i];
          led_oe_reg[i]  <= i_led_od[i] ? led_on[i] : 1'b1;
        end
      end
    end
  end

  // interrupt, reset status and wake pin
  assign int_next = (int_reg && !i_int_clr) || new_touch || pin_rel || led_alert;

  always_ff @(posedge i_clk_sys) begin
    if (rst) begin
      int_reg      <= 1'b0;
      alert_n_reg  <= 1'b1;
      rst_stat_reg <= 1'b0;
      wake_reg     <= 1'b0;
      wake_oe_reg  <= 1'b0;
    end else begin
      int_reg      <= int_next;
      alert_n_reg  <= !int_next;
      rst_stat_reg <= pin_rel || (rst_stat_reg && !i_reset_status_clr);
      wake_oe_reg  <= ps_next == PS_STANDBY && !i_spi4_mode;
      if (ps_reg == PS_STANDBY && !i_spi4_mode && new_touch) begin
        wake_reg <= 1'b1;
      end else if (!int_next || ps_next != PS_STANDBY) begin
        wake_reg <= 1'b0;
      end
    end
  end

  assign o_meas_req         = req_reg;
  assign o_meas_chan        = ch_reg;
  assign o_touch            = touch_reg;
  assign o_cal_active       = cal_reg;
  assign o_pwr_state        = ps_reg;
  assign o_lowest_power_bit = lp_reg;
  assign o_reset_status     = rst_stat_reg;
  assign o_int_bit          = int_reg;
  assign o_alert_n          = alert_n_reg;
  assign o_wake_out         = wake_reg;
  assign o_wake_oe          = wake_oe_reg;
  assign o_led_out          = led_out_reg;
  assign o_led_oe           = led_oe_reg;

  property p_sleep_sel;
    @(posedge i_clk_sys) disable iff (rst) (lp_reg && !i_bus_active) |=> ps_reg == PS_SLEEP;
  endproperty
  a_sleep_sel: assert property (p_sleep_sel) else $error("lowest power bit did not select sleep");
  property p_clear_inactive;
    @(posedge i_clk_sys) disable iff (rst) (ps_next != ps_reg) |=> (touch_reg & ~act_reg) == TOUCH_RST;
  endproperty
  a_clear_inactive: assert property (p_clear_inactive) else $error("touch kept on inactive input");
  property p_no_scan_sleep;
    @(posedge i_clk_sys) disable iff (rst) (ps_reg == PS_SLEEP && !req_reg) |=> !req_reg;
  endproperty
  a_no_scan_sleep: assert property (p_no_scan_sleep) else $error("sampling while asleep");
  property p_wake_clears;
    @(posedge i_clk_sys) disable iff (rst) (wake_hit && !i_lowest_power_set) |=> !lp_reg ##1 ps_reg != PS_SLEEP;
  endproperty
  a_wake_clears: assert property (p_wake_clears) else $error("wake pin did not leave sleep");
  property p_reset_hold;
    @(posedge i_clk_sys) disable iff (!i_reset_n) pin_sync_reg[1] |=> touch_reg == TOUCH_RST && led_oe_reg == 2'h0 && lp_reg;
  endproperty
  a_reset_hold: assert property (p_reset_hold) else $error("state not held in reset");
  property p_reset_release;
    @(posedge i_clk_sys) disable iff (!i_reset_n) $fell(pin_sync_reg[1]) |=> int_reg && rst_stat_reg && !alert_n_reg;
  endproperty
  a_reset_release: assert property (p_reset_release) else $error("reset release not flagged");
  property p_wake_drive;
    @(posedge i_clk_sys) disable iff (rst) (ps_reg == PS_STANDBY && !i_spi4_mode && new_touch) |=> o_wake_out;
  endproperty
  a_wake_drive: assert property (p_wake_drive) else $error("wake not driven on standby touch");
  property p_wake_hiz;
    @(posedge i_clk_sys) disable iff (rst) (ps_next == PS_SLEEP || i_spi4_mode) |=> !o_wake_oe;
  endproperty
  a_wake_hiz: assert property (p_wake_hiz) else $error("wake pin driven while input");
  property p_scan_order;
    @(posedge i_clk_sys) disable iff (rst) mv |=> ch_reg == $past(ch_reg) + 3'h1;
  endproperty
  a_scan_order: assert property (p_scan_order) else $error("scan did not advance");
  property p_touch_int;
    @(posedge i_clk_sys) disable iff (rst) new_touch |=> int_reg && !alert_n_reg;
  endproperty
  a_touch_int: assert property (p_touch_int) else $error("touch raised no interrupt");
  property p_int_hold;
    @(posedge i_clk_sys) disable iff (rst) (int_reg && !i_int_clr) |=> int_reg && !alert_n_reg;
  endproperty
  a_int_hold: assert property (p_int_hold) else $error("interrupt bit dropped");
endmodule
`default_nettype wire

//--- rtl/tsp_pkg.sv
// shared constants and types of the touch sense control core
package tsp_pkg;
  localparam int NCH      = 8;
  localparam int NLED     = 2;
  localparam int MW       = 16;
  localparam int DW       = 4;
  localparam int CLK_HZ   = 100_000_000;
  localparam int CAL_TIME_MS = 200;
  localparam int CAL_CYC  = CAL_TIME_MS * (CLK_HZ / 1000);
  localparam int PRE_DIV_DEF = 1000;
  localparam int AVG_N    = 64;
  localparam int AVG_SH   = 6;
  localparam logic [5:0] AVG_LAST = 6'(AVG_N - 1);
  localparam logic [NCH-1:0] TOUCH_RST = 8'h00;
  localparam logic [NCH-1:0] CAL_ALL = 8'hFF;
  localparam logic [DW-1:0] LVL_FULL = 4'hF;
  localparam logic [DW-1:0] LVL_OFF = 4'h0;

  typedef enum logic [1:0] {
    PS_ACTIVE  = 2'b00,
    PS_STANDBY = 2'b01,
    PS_SLEEP   = 2'b10
  } tsp_pwr_t;

  typedef enum logic [1:0] {
    LM_DIRECT  = 2'b00,
    LM_PULSE1  = 2'b01,
    LM_PULSE2  = 2'b10,
    LM_BREATHE = 2'b11
  } tsp_led_mode_t;
endpackage

//--- sim/tsp_core_tb.sv
// self-checking bench of the touch sense control core
`timescale 1ns/1ps
`default_nettype none
module tsp_core_tb
  import tsp_pkg::*;
;
  typedef struct {logic [1:0] host, inv, od; logic on;} tsp_row_t;
  tsp_row_t rows [4] = '{'{2'h2, 2'h0, 2'h0, 1}, '{2'h2, 2'h2, 2'h0, 0}, '{2'h0, 2'h2, 2'h2, 1}, '{2'h2, 2'h0, 2'h2, 1}};
  logic i_clk_sys = 0, i_reset_n = 0, i_reset_pin = 0, i_low_power_monitor_bit = 0, i_lowest_power_set = 0;
  logic i_bus_active = 0, i_spi4_mode = 0, wdrv = 0, i_auto_recal_en = 1, i_int_clr = 0, i_reset_status_clr = 0;
  logic [7:0] i_chan_en = 8'h25, i_standby_en = 8'h04, i_cal_set = 8'h00, press = 8'h00;
  logic [7:0] i_led_min = 8'h00, i_led_max = 8'hFF;
  logic [15:0] i_threshold = 16'h0100;
  logic [3:0] i_led_mode = 4'h0;
  logic [1:0] i_led_link = 2'h1, i_led_host = 2'h0, i_led_inv = 2'h0, i_led_od = 2'h0, i_led_ramp = 2'h0;
  logic [1:0] i_led_alert_en = 2'h0;
  wire i_meas_valid, o_meas_req, o_lowest_power_bit, o_reset_status, o_int_bit, o_alert_n, o_wake_out, o_wake_oe;
  wire [15:0] i_meas_data;
  wire [7:0] o_touch, o_cal_active;
  wire [2:0] o_meas_chan;
  wire [1:0] o_pwr_state, o_led_out, o_led_oe;
  wire i_wake_in = o_wake_oe ? o_wake_out : wdrv;
  int num_errors = 0, comparisons = 0, i, n;
  logic [2:0] q [$];
  always #5 i_clk_sys = ~i_clk_sys;
  always @(posedge i_clk_sys) if (i_meas_valid && o_meas_req) q.push_back(o_meas_chan);
  tsp_core #(.CAL_CYCLES(50), .PRE_DIV(2)) dut (.i_clk_sys, .i_reset_n, .i_reset_pin, .i_low_power_monitor_bit,
    .i_lowest_power_set, .i_bus_active, .i_spi4_mode, .i_wake_in, .i_chan_en, .i_standby_en, .i_cal_set,
    .i_auto_recal_en, .i_threshold, .i_meas_valid, .i_meas_data, .i_int_clr, .i_reset_status_clr, .i_led_mode,
    .i_led_link, .i_led_host, .i_led_inv, .i_led_od, .i_led_ramp, .i_led_trig_rel(2'h0), .i_led_alert_en,
    .i_led_min, .i_led_max, .i_led_count(8'h22), .i_led_offdly(8'h00), .i_led_rate(16'h0101), .o_meas_req,
    .o_meas_chan, .o_touch, .o_cal_active, .o_pwr_state, .o_lowest_power_bit, .o_reset_status, .o_int_bit,
    .o_alert_n, .o_wake_out, .o_wake_oe, .o_led_out, .o_led_oe);
  tsp_meas_model fe (.i_clk_sys, .i_req(o_meas_req), .i_chan(o_meas_chan), .i_pressed(press),
    .o_valid(i_meas_valid), .o_data(i_meas_data));
  task automatic cyc(input int k);
    repeat (k) @(negedge i_clk_sys);
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic led_count(input int k);
    n = 0;
    repeat (32) begin
      cyc(1);
      n += i_led_od[k] ? o_led_oe[k] : o_led_out[k];
    end
  endtask
  task automatic pulse_clr;
    i_int_clr = 1;
    cyc(1);
    i_int_clr = 0;
    cyc(2);
  endtask
  function automatic logic [2:0] nxt(input logic [2:0] c);
    logic [2:0] m;
    m = c + 3'h1;
    while (!i_chan_en[m]) m = m + 3'h1;
    return m;
  endfunction
  task automatic final_report;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #100us;
    num_errors++;
    final_report;
  end
  initial begin
    cyc(16);
    i_reset_n = 1;
    cyc(20);
    chk(o_pwr_state, PS_SLEEP);
    chk(o_meas_req, 0);
    chk(o_wake_oe, 0);
    i_spi4_mode = 1;
    wdrv = 1;
    cyc(6);
    chk(o_lowest_power_bit, 1);
    i_spi4_mode = 0;
    cyc(4);
    wdrv = 0;
    chk(o_pwr_state, PS_ACTIVE);
    chk(o_cal_active, CAL_ALL);
    for (i = 0; i < 300 && o_cal_active !== 8'h00; i++) cyc(1);
    chk(o_cal_active, 0);
    i_cal_set = 8'h04;
    cyc(1);
    i_cal_set = 8'h00;
    cyc(1);
    chk(o_cal_active, 8'h04);
    for (i = 0; i < 80 && o_cal_active !== 8'h00; i++) cyc(1);
    chk(o_cal_active, 0);
    q.delete();
    cyc(40);
    for (i = 0; i + 1 < q.size(); i++) chk(q[i+1], nxt(q[i]));
    press = 8'h01;
    for (i = 0; i < 60 && o_touch[0] !== 1'b1; i++) cyc(1);
    chk({o_touch, o_int_bit, o_alert_n}, 10'h006);
    led_count(0);
    chk(n >= 28, 1);
    for (i = 0; i < 4; i++) begin
      {i_led_host, i_led_inv, i_led_od} = {rows[i].host, rows[i].inv, rows[i].od};
      cyc(4);
      led_count(1);
      chk(rows[i].on ? n >= 28 : n == 0, 1);
    end
    i_led_host = 2'h0;
    pulse_clr();
    // host driven led 1 in pulse1 mode, two pulses of 4-cycle steps, alert on completion
    {i_led_mode, i_led_alert_en, i_led_host} = {4'h4, 2'h2, 2'h2};
    cyc(200);
    chk({o_int_bit, o_alert_n}, 2'h1);
    for (i = 0; i < 150 && o_alert_n !== 1'b0; i++) cyc(1);
    chk({o_int_bit, o_alert_n}, 2'h2);
    {i_led_mode, i_led_alert_en} = 6'h00;
    i_led_od = 2'h0;
    i_low_power_monitor_bit = 1;
    cyc(4);
    chk(o_pwr_state, PS_STANDBY);
    chk(o_touch[0], 0);
    press = 8'h00;
    pulse_clr();
    chk({o_int_bit, o_alert_n}, 2'h1);
    q.delete();
    cyc(30);
    foreach (q[k]) chk(q[k], 2);
    press = 8'h04;
    for (i = 0; i < 60 && o_wake_out !== 1'b1; i++) cyc(1);
    chk({o_wake_oe, o_wake_out, o_int_bit}, 3'h7);
    press = 8'h00;
    for (i = 0; i < 60 && o_touch[2] !== 1'b0; i++) cyc(1);
    chk({o_wake_oe, o_wake_out}, 2'h3);
    pulse_clr();
    chk(o_wake_oe & o_wake_out, 0);
    i_low_power_monitor_bit = 0;
    for (i = 0; i < 20 && (o_cal_active & 8'h21) !== 8'h21; i++) cyc(1);
    chk(o_cal_active & 8'h21, 8'h21);
    chk(o_pwr_state, PS_ACTIVE);
    i_lowest_power_set = 1;
    cyc(1);
    i_lowest_power_set = 0;
    cyc(4);
    q.delete();
    cyc(20);
    chk(o_pwr_state, PS_SLEEP);
    chk(q.size(), 0);
    chk({o_led_out[0], o_led_oe[0]}, 2'h1);
    i_bus_active = 1;
    cyc(4);
    chk({o_pwr_state != PS_SLEEP, o_lowest_power_bit}, 2'h3);
    i_bus_active = 0;
    cyc(4);
    chk(o_pwr_state, PS_SLEEP);
    i_reset_pin = 1;
    cyc(4);
    chk({o_led_oe, o_wake_oe, o_alert_n, o_lowest_power_bit}, 5'h03);
    i_reset_pin = 0;
    cyc(5);
    chk({o_reset_status, o_int_bit, o_alert_n}, 3'h6);
    i_reset_status_clr = 1;
    cyc(1);
    i_reset_status_clr = 0;
    cyc(2);
    chk(o_reset_status, 0);
    final_report;
  end
endmodule
`default_nettype wire

//--- sim/tsp_meas_model.sv
// measurement front end model answering the core's scan requests
`timescale 1ns/1ps
`default_nettype none
module tsp_meas_model
  import tsp_pkg::*;
(
  input  wire logic           i_clk_sys,
  input  wire logic           i_req,
  input  wire logic [2:0]     i_chan,
  input  wire logic [NCH-1:0] i_pressed,
  output logic                o_valid,
  output logic [MW-1:0]       o_data
);
  logic [1:0] wait_reg;
  initial begin
    o_valid = 1'b0;
    o_data = 16'h0000;
    wait_reg = 2'h0;
  end
  // answers every request on its second cycle; data toggles when not valid
  always @(posedge i_clk_sys) begin
    o_valid <= 1'b0;
    o_data <= ~o_data;
    if (i_req && !o_valid) begin
      wait_reg <= wait_reg + 2'h1;
      if (wait_reg[0]) begin
        o_valid <= 1'b1;
        o_data <= i_pressed[i_chan] ? 16'h0300 : 16'h0100;
      end
    end
  end
endmodule
`default_nettype wire
